// file: common/pmt_pkg.sv
/*
  Shared constants and types for the period match timer: register
  offsets, field positions, reset values and the prescale encoding.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package pmt_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_PERIOD = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_IRQ_ENABLES = 8'h10;

  // Control field positions
  localparam int POST_LSB = 3;
  localparam int POST_MSB = 6;
  localparam int RUN_BIT = 2;
  localparam int PRE_LSB = 0;
  localparam int PRE_MSB = 1;

  // Interrupt bit position in flag and enable registers
  localparam int MATCH_BIT = 0;

  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] COUNT_RST = 8'h00;

  // Instruction clock is the system clock divided by four
  localparam int INSTR_DIV = 4;

  // Prescale select encodings
  typedef enum logic [1:0] {
    PRE_DIV1 = 2'b00,
    PRE_DIV4 = 2'b01,
    PRE_DIV16 = 2'b10,
    PRE_DIV64 = 2'b11
  } prescale_t;

  // Decoded control register
  typedef struct packed {
    logic unused7;
    logic [3:0] postscale_select;
    logic timer_run;
    prescale_t prescale_select;
  } control_t;

  // Timer events toward other units
  typedef struct packed {
    logic period_match;
    logic post_match;
  } events_t;

endpackage

// file: design/pmt_prescaler.sv
/*
  Prescale divider: makes a one-cycle tick every 1, 4, 16 or 64
  input enables. Assumes the enable comes from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pmt_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic step,
  input wire pmt_pkg::prescale_t sel,
  output logic tick
);

  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [5:0] last;

  // Terminal count of the selected ratio
  assign last = (sel == pmt_pkg::PRE_DIV1) ? 6'h00 :
                (sel == pmt_pkg::PRE_DIV4) ? 6'h03 :
                (sel == pmt_pkg::PRE_DIV16) ? 6'h0f : 6'h3f;
  assign tick = step && (cnt_q >= last);
  assign cnt_d = tick ? 6'h00 : cnt_q + 6'h01;

  // Counter, cleared on reset or count and control register writes
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      cnt_q <= 6'h00;
    end else if (step) begin
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// file: design/period_match_timer.sv
/*
  Period match timer with prescaler, postscaler, match interrupt and
  APB register access. Assumes one 100 MHz clock, a synchronous
  active-low reset and a sleep level from the core's clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Each period match steps a 4-bit postscale counter giving the interrupt event.
// - Postscale count complete sets the sticky match interrupt flag.
// - Match interrupt reaches the core only while its enable bit is set.
// - Control bits 6..3 value n gives postscale ratio 1:(n+1).
// - Control bit 2 runs the timer when one, halts it when zero.
// - Control bits 1..0 select prescale divide by 1, 4, 16 or 64.
// - Unscaled match pulse goes out as PWM time base.
// - First instance also offers its output as SPI shift clock.
// - Timer does not advance during sleep.
// - Count and period registers hold their values during sleep.
// - Count starts at zero, increments per prescaled instruction clock tick.
// - Count equal to period gives match pulse and zero next tick.
// - Count or control writes and reset clear prescale and postscale.
// - Reset clears count and sets period to all ones; control write keeps count.
module period_match_timer #(
  parameter bit FIRST_INSTANCE = 1'b1
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SLEEP,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic PERIOD_MATCH,
  output logic SPI_SHIFT_CLK,
  output logic IRQ
);

  pmt_pkg::control_t control_q;
  logic [7:0] period_q;
  logic [7:0] count_q;
  logic [3:0] post_q;
  logic [1:0] instr_q;
  logic flag_q;
  logic enable_q;
  logic match_q;
  logic spi_q;
  logic irq_q;
  logic [31:0] rdata_q;
  logic ready_q;
  logic err_q;

  // APB decode
  logic access;
  logic wr;
  logic rd;
  logic lane0;
  logic hit_ctl;
  logic hit_per;
  logic hit_cnt;
  logic hit_flg;
  logic hit_ena;
  logic mapped;
  logic [7:0] wbyte;

  assign access = PSEL && PENABLE && !ready_q;
  assign wr = access && PWRITE;
  assign rd = access && !PWRITE;
  assign lane0 = PSTRB[0];
  assign wbyte = PWDATA[7:0];
  assign hit_ctl = (PADDR == pmt_pkg::OFF_CONTROL);
  assign hit_per = (PADDR == pmt_pkg::OFF_PERIOD);
  assign hit_cnt = (PADDR == pmt_pkg::OFF_COUNT);
  assign hit_flg = (PADDR == pmt_pkg::OFF_IRQ_FLAGS);
  assign hit_ena = (PADDR == pmt_pkg::OFF_IRQ_ENABLES);
  assign mapped = hit_ctl || hit_per || hit_cnt || hit_flg || hit_ena;

  logic wr_ctl;
  logic wr_per;
  logic wr_cnt;
  logic wr_flg;
  logic wr_ena;
  assign wr_ctl = wr && hit_ctl && lane0;
  assign wr_per = wr && hit_per && lane0;
  assign wr_cnt = wr && hit_cnt && lane0;
  assign wr_flg = wr && hit_flg && lane0;
  assign wr_ena = wr && hit_ena && lane0;

  // Read data selection, reserved bits zero
  logic [7:0] rsel;
  assign rsel = hit_ctl ? {1'b0, control_q.postscale_select, control_q.timer_run,
                           control_q.prescale_select} :
                hit_per ? period_q :
                hit_cnt ? count_q :
                hit_flg ? {7'h00, flag_q} :
                hit_ena ? {7'h00, enable_q} : 8'h00;

  // APB answer: one wait state, error on unmapped address
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ready_q <= access;
      err_q <= access && !mapped;
      if (rd) begin
        rdata_q <= {24'h00_0000, rsel};
      end
    end
  end

  assign PREADY = ready_q;
  assign PSLVERR = err_q;
  assign PRDATA = rdata_q;

  // Instruction clock enable, system clock divided by four
  logic instr_tick;
  assign instr_tick = (instr_q == 2'(pmt_pkg::INSTR_DIV - 1));
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      instr_q <= 2'b00;
    end else begin
      instr_q <= instr_q + 2'b01;
    end
  end

  logic step;
  assign step = instr_tick && control_q.timer_run && !SLEEP;

  logic scale_clear;
  assign scale_clear = wr_cnt || wr_ctl;

  logic pre_tick;
  pmt_prescaler u_pre (
    .clk(MCLK),
    .rst_n(RST_N),
    .clear(scale_clear),
    .step(step),
    .sel(control_q.prescale_select),
    .tick(pre_tick)
  );

  logic match;
  assign match = pre_tick && (count_q == period_q);

  logic post_done;
  assign post_done = match && (post_q == control_q.postscale_select);

  // Control register
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      control_q <= pmt_pkg::control_t'(pmt_pkg::CONTROL_RST);
    end else if (wr_ctl) begin
      control_q <= pmt_pkg::control_t'({1'b0, wbyte[6:0]});
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      period_q <= pmt_pkg::PERIOD_RST;
    end else if (wr_per && !SLEEP) begin
      period_q <= wbyte;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      count_q <= pmt_pkg::COUNT_RST;
    end else if (wr_cnt && !SLEEP) begin
      count_q <= wbyte;
    end else if (match) begin
      count_q <= 8'h00;
    end else if (pre_tick) begin
      count_q <= count_q + 8'h01;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N || scale_clear) begin
      post_q <= 4'h0;
    end else if (post_done) begin
      post_q <= 4'h0;
    end else if (match) begin
      post_q <= post_q + 4'h1;
    end
  end

  // sticky flag, set wins over write-one clear
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      flag_q <= 1'b0;
    end else if (post_done) begin
      flag_q <= 1'b1;
    end else if (wr_flg && wbyte[pmt_pkg::MATCH_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  // Match interrupt enable
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      enable_q <= 1'b0;
    end else if (wr_ena) begin
      enable_q <= wbyte[pmt_pkg::MATCH_BIT];
    end
  end

  logic flag_d;
  logic enable_d;
  assign flag_d = post_done ? 1'b1 :
                  (wr_flg && wbyte[pmt_pkg::MATCH_BIT]) ? 1'b0 : flag_q;
  assign enable_d = wr_ena ? wbyte[pmt_pkg::MATCH_BIT] : enable_q;

  // match and shift clock outputs, interrupt level
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      match_q <= 1'b0;
      spi_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      match_q <= match;
      if (FIRST_INSTANCE && match) begin
        spi_q <= !spi_q;
      end
      irq_q <= flag_d && enable_d;
    end
  end

  assign PERIOD_MATCH = match_q;
  assign SPI_SHIFT_CLK = spi_q;
  assign IRQ = irq_q;

endmodule
`default_nettype wire

// file: test/pmt_sva.sv
/*
  Port checker for the period match timer.
  Assumes one clock and the one wait state APB answer.
*/
`timescale 1ns/1ps
`default_nettype none
module pmt_sva (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SLEEP,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic PREADY,
  input wire logic PERIOD_MATCH,
  input wire logic SPI_SHIFT_CLK,
  input wire logic IRQ
);
  logic run_q;
  logic en_q;
  wire logic wr = PSEL && PENABLE && PWRITE && !PREADY && PSTRB[0];
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Mirror of run and enable bits
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      run_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      if (wr && PADDR == pmt_pkg::OFF_CONTROL) run_q <= PWDATA[pmt_pkg::RUN_BIT];
      if (wr && PADDR == pmt_pkg::OFF_IRQ_ENABLES) en_q <= PWDATA[pmt_pkg::MATCH_BIT];
    end
  end
  chk_match_gap: assert property (PERIOD_MATCH |=> !PERIOD_MATCH [*3])
    else $error("match pulses too close");
  chk_halt_quiet: assert property (!run_q [*4] |-> !PERIOD_MATCH)
    else $error("match while halted");
  chk_sleep_quiet: assert property (SLEEP [*4] |-> !PERIOD_MATCH)
    else $error("match during sleep");
  chk_spi_follow: assert property ($changed(SPI_SHIFT_CLK) |-> PERIOD_MATCH || $past(PERIOD_MATCH))
    else $error("shift clock moved without match");
  chk_spi_toggle: assert property ($rose(PERIOD_MATCH) |-> ##[0:1] $changed(SPI_SHIFT_CLK))
    else $error("shift clock missed a match");
  chk_irq_hold: assert property (IRQ && !(PSEL && PENABLE && PWRITE && !PREADY) |=> IRQ)
    else $error("irq dropped without a write");
  chk_irq_mask: assert property (!en_q [*2] |-> !IRQ)
    else $error("irq while disabled");
  chk_irq_rise: assert property ($rose(IRQ) |-> en_q)
    else $error("irq rose while disabled");
endmodule
bind period_match_timer pmt_sva pmt_sva_i (.MCLK(MCLK), .RST_N(RST_N), .SLEEP(SLEEP),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PSTRB(PSTRB), .PREADY(PREADY), .PERIOD_MATCH(PERIOD_MATCH),
  .SPI_SHIFT_CLK(SPI_SHIFT_CLK), .IRQ(IRQ));
`default_nettype wire

// file: test/pmt_pwm_model.sv
/*
  PWM and shift clock user of the timer outputs.
  Assumes both outputs are levels in the timer clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pmt_pwm_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic base,
  input wire logic sclk,
  output int pulses,
  output int edges
);
  logic last;
  // Counts time base pulses and shift clock edges
  always @(posedge clk) begin
    last <= sclk;
    if (!rst_n) begin
      pulses <= 0;
      edges <= 0;
    end else begin
      if (base === 1'b1) pulses <= pulses + 1;
      if (sclk !== last) edges <= edges + 1;
    end
  end
endmodule
`default_nettype wire

// file: test/period_match_timer_tb.sv
/*
  Testbench for the period match timer over APB.
  Assumes the checker binds itself to the timer.
*/
`timescale 1ns/1ps
`default_nettype none
module period_match_timer_tb;
  logic MCLK = 1'b0, RST_N = 1'b0, SLEEP = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd, sv;
  logic [3:0] PSTRB = 4'hf;
  logic PREADY, PSLVERR, PERIOD_MATCH, SPI_SHIFT_CLK, IRQ, err;
  logic [7:0] rv[5] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  int error_cnt = 0, compares = 0, pulses, edges, c, n;
  int ps[2] = '{0, 15};
  period_match_timer period_match_timer_i (.MCLK(MCLK), .RST_N(RST_N), .SLEEP(SLEEP),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PERIOD_MATCH(PERIOD_MATCH), .SPI_SHIFT_CLK(SPI_SHIFT_CLK), .IRQ(IRQ));
  pmt_pwm_model pmt_pwm_model_i (.clk(MCLK), .rst_n(RST_N), .base(PERIOD_MATCH),
    .sclk(SPI_SHIFT_CLK), .pulses(pulses), .edges(edges));
  // Clock of 10 ns
  initial forever #5 MCLK = ~MCLK;
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic hang();
    error_cnt++;
    $display("CHECK FAILED %0t wait ran out", $time);
    final_report();
  endtask
  // One APB transfer held until PREADY, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    for (c = 0; c < 20 && PREADY !== 1'b1; c++) @(posedge MCLK);
    if (c == 20) hang();
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask
  // Cycles up to the next match pulse
  task automatic wait_match();
    for (c = 1; c < 9000; c++) begin
      @(posedge MCLK);
      if (PERIOD_MATCH === 1'b1) return;
    end
    hang();
  endtask
  initial begin
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, {24'h0, rv[i]});
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    $display("reset test done");
    apb(1'b1, pmt_pkg::OFF_PERIOD, 32'h1);
    apb(1'b1, pmt_pkg::OFF_IRQ_ENABLES, 32'h1);
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, pmt_pkg::OFF_CONTROL, 32'h4 | p);
      wait_match();
      wait_match();
      chk(c, 8 << (2 * p));
    end
    chk(edges, pulses);
    $display("prescale test done");
    foreach (ps[j]) begin
      apb(1'b1, pmt_pkg::OFF_CONTROL, 32'h0);
      apb(1'b1, pmt_pkg::OFF_IRQ_FLAGS, 32'h1);
      apb(1'b1, pmt_pkg::OFF_CONTROL, (ps[j] << 3) | 4);
      for (int k = 0; k <= ps[j]; k++) begin
        chk(IRQ, 1'b0);
        wait_match();
      end
      repeat (3) @(posedge MCLK);
      chk(IRQ, 1'b1);
    end
    $display("postscale test done");
    apb(1'b1, pmt_pkg::OFF_CONTROL, 32'h0);
    apb(1'b1, pmt_pkg::OFF_IRQ_ENABLES, 32'h0);
    chk(IRQ, 1'b0);
    apb(1'b0, pmt_pkg::OFF_IRQ_FLAGS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, pmt_pkg::OFF_IRQ_ENABLES, 32'h1);
    chk(IRQ, 1'b1);
    apb(1'b1, pmt_pkg::OFF_IRQ_FLAGS, 32'h1);
    chk(IRQ, 1'b0);
    $display("interrupt test done");
    apb(1'b1, pmt_pkg::OFF_COUNT, 32'h40);
    apb(1'b1, pmt_pkg::OFF_CONTROL, 32'h78);
    n = pulses;
    repeat (50) @(posedge MCLK);
    apb(1'b0, pmt_pkg::OFF_COUNT, 32'h0);
    chk(rd, 32'h40);
    chk(pulses, n);
    $display("halt test done");
    apb(1'b1, pmt_pkg::OFF_PERIOD, 32'hff);
    apb(1'b1, pmt_pkg::OFF_CONTROL, 32'h4);
    SLEEP <= 1'b1;
    apb(1'b0, pmt_pkg::OFF_COUNT, 32'h0);
    sv = rd;
    repeat (100) @(posedge MCLK);
    apb(1'b1, pmt_pkg::OFF_COUNT, 32'h5);
    apb(1'b0, pmt_pkg::OFF_COUNT, 32'h0);
    chk(rd, sv);
    apb(1'b0, pmt_pkg::OFF_PERIOD, 32'h0);
    chk(rd, 32'hff);
    SLEEP <= 1'b0;
    $display("sleep test done");
    final_report();
  end
endmodule
`default_nettype wire
